/* verilog/clcd_pkg.sv */
// Constants, types and timing figures for the character display command core.
// Assumes a single 125 MHz system clock; execution times are counted in it.
package clcd_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // Execution times as printed, in nanoseconds
  localparam int unsigned T_SHORT_NS = 18500;
  localparam int unsigned T_LONG_NS = 760000;
  // Cycle counts; all figures round down, with no lower bound
  localparam int unsigned T_SHORT_CYC = (T_SHORT_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned T_LONG_CYC = (T_LONG_NS * 1000) / CLK_PERIOD_PS;

  // Memory sizes
  localparam int unsigned DISP_RAM_DEPTH = 128;
  localparam int unsigned FONT_RAM_DEPTH = 64;

  // Address ranges per line mode
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4f;

  // Scan geometry
  localparam int unsigned SEG_LINES = 40;
  localparam int unsigned COM_TWO_LINE = 16;
  localparam int unsigned COM_ONE_LINE = 8;

  // Fixed codes and reset values
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] ADDR_HOME = 7'h00;
  localparam logic BUS_WIDTH_RST = 1'b1;

  // Core state
  typedef enum logic [1:0] {
    CLCD_IDLE,
    CLCD_CLEAR,
    CLCD_BUSY
  } clcd_state_e;

endpackage : clcd_pkg

/* verilog/clcd_font_lookup.sv */
// Character code to five-dot font row lookup.
// Assumes the caller supplies the user font byte for code[2:0] and row.
`timescale 1ns/1ns
`default_nettype none
module clcd_font_lookup
  import clcd_pkg::*;
(
  input wire logic [7:0] char_code,
  input wire logic [2:0] row,
  input wire logic [7:0] user_font_byte,
  input wire logic cursor_here,
  output logic [4:0] dots,
  output logic [5:0] user_font_addr
);
  // Stand-in fixed font: real art is a constant table of 256 x 8 rows
  function automatic logic [4:0] rom_row(input logic [7:0] code, input logic [2:0] r);
    rom_row = code[4:0] ^ {r, r[1:0]};
  endfunction

  logic use_user;
  logic [4:0] base;

  // Code bits 2..0 pick the pattern, row picks the line; bit 3 ignored
  assign user_font_addr = {char_code[2:0], row};
  assign use_user = (char_code[7:4] == 4'h0);

  // Lit dot is a one; bit 4 leftmost; upper bits dropped
  always_comb begin
    if (use_user) begin
      base = user_font_byte[4:0];
    end else begin
      base = rom_row(char_code, row);
    end
    // Eighth row is ORed with the cursor
    if (row == 3'h7 && cursor_here) begin
      dots = 5'h1f;
    end else begin
      dots = base;
    end
  end
endmodule : clcd_font_lookup
`default_nettype wire

/* verilog/clcd_core.sv */
// Instruction decoder, address counter and RAM access for a character display.
// Assumes bus pins arrive asynchronously and are sampled on clk; the host
// checks the busy flag before each new instruction.
// Summary of operation
// - Step counter after each RAM access
// - Status read shows counter on bits 6..0
// - Scan 16 or 8 commons, 40 segments
// - Fixed 256-character 5x8 font table
// - Code bits 2..0 give font address 5..3
// - Font address 2..0 select row; cursor ORed
// - Row dots from bits 4..0, bit4 left
// - User font when code bits 7..4 zero
// - One means lit dot
// - Data write stores into selected RAM
// - Data read returns byte at address
// - Clear fills spaces, counter zero
// - Home zeroes counter, undoes shift
// - Entry mode latches direction and shift
// - Display control latches display, cursor, blink
// - Shift moves cursor or display
// - Function set latches width, lines, font
// - Font address set selects font RAM
// - Display address set selects display RAM
// - Busy blocks new instructions
// - Select and direction choose operation
// - Four-bit mode joins two transfers
// - Line address ranges per line mode
`timescale 1ns/1ns
`default_nettype none
module clcd_core
  import clcd_pkg::*;
#(
  parameter int unsigned SHORT_CYCLES = T_SHORT_CYC,
  parameter int unsigned LONG_CYCLES = T_LONG_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_select,
  input wire logic read_not_write,
  input wire logic enable,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic busy_flag,
  output logic bus_width_8,
  output logic two_line,
  output logic font_tall,
  output logic display_on,
  output logic cursor_on,
  output logic blink_on,
  output logic [6:0] display_shift,
  output logic [4:0] com_count,
  output logic [5:0] seg_count,
  input wire logic [6:0] scan_addr,
  input wire logic [2:0] scan_row,
  output logic [4:0] scan_dots
);
  // All state of the core except the two RAMs
  typedef struct packed {
    logic [2:0] sync_rs;       // Two-stage sync plus edge history
    logic [2:0] sync_rw;
    logic [2:0] sync_en;
    logic [15:0] sync_d;       // Two stages of data pins
    logic [6:0] addr_counter;
    logic to_font;             // Target RAM from last address set, clear or home
    logic incr;
    logic shift_en;
    logic bus_width_8;
    logic two_line;
    logic font_tall;
    logic display_on;
    logic cursor_on;
    logic blink_on;
    logic [6:0] shift;
    logic nib_hi_done;         // First nibble held
    logic [3:0] nib_hi;
    logic [7:0] data_reg;      // Prefetched read data
    logic [7:0] rd_out;
    logic [19:0] busy_cnt;
    logic [6:0] clr_addr;
    clcd_state_e state;
  } clcd_s;

  clcd_s st_reg, st_next;

  // Storage: flip-flop arrays addressed by index
  logic [7:0] display_ram [DISP_RAM_DEPTH];
  logic [7:0] user_font_ram [FONT_RAM_DEPTH];
  logic ram_we;
  logic [6:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic ram_wfont;

  // Wrap the counter inside the ranges of the line mode
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                           input logic font, input logic two);
    logic [6:0] n;
    n = up ? a + 7'h01 : a - 7'h01;
    if (font) begin
      step_addr = {1'b0, n[5:0]};
    end else if (two) begin
      if (up && a == LINE1_LAST) step_addr = LINE2_FIRST;
      else if (up && a == LINE2_LAST) step_addr = ADDR_HOME;
      else if (!up && a == ADDR_HOME) step_addr = LINE2_LAST;
      else if (!up && a == LINE2_FIRST) step_addr = LINE1_LAST;
      else step_addr = n;
    end else begin
      if (up && a == ONE_LINE_LAST) step_addr = ADDR_HOME;
      else if (!up && a == ADDR_HOME) step_addr = ONE_LINE_LAST;
      else step_addr = n;
    end
  endfunction

  // Fetch the byte at an address from the selected RAM
  function automatic logic [7:0] ram_read(input logic [6:0] a, input logic font);
    ram_read = font ? user_font_ram[a[5:0]] : display_ram[a];
  endfunction

  logic en_fall;
  logic rs_s, rw_s;
  logic [7:0] din_s;
  logic [7:0] byte_v;
  logic byte_ok;
  logic [6:0] na;

  assign rs_s = st_reg.sync_rs[1];
  assign rw_s = st_reg.sync_rw[1];
  assign din_s = st_reg.sync_d[15:8];
  // Transfer completes on the falling edge of enable
  assign en_fall = st_reg.sync_en[2] && !st_reg.sync_en[1];

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    ram_we = 1'b0;
    ram_waddr = st_reg.addr_counter;
    ram_wdata = din_s;
    ram_wfont = st_reg.to_font;
    byte_v = din_s;
    byte_ok = 1'b0;
    na = st_reg.addr_counter;
    // Synchroniser chains; stage two is read, and stage three of enable for its edge
    st_next.sync_rs = {st_reg.sync_rs[1:0], reg_select};
    st_next.sync_rw = {st_reg.sync_rw[1:0], read_not_write};
    st_next.sync_en = {st_reg.sync_en[1:0], enable};
    st_next.sync_d = {st_reg.sync_d[7:0], data_in};
    // Busy countdown
    if (st_reg.busy_cnt != 20'h0_0000) begin
      st_next.busy_cnt = st_reg.busy_cnt - 20'h0_0001;
    end
    // Assemble a byte: nibbles in four-bit mode, upper first
    if (en_fall && !st_reg.bus_width_8) begin
      if (!st_reg.nib_hi_done) begin
        st_next.nib_hi = din_s[7:4];
        st_next.nib_hi_done = 1'b1;
      end else begin
        byte_v = {st_reg.nib_hi, din_s[7:4]};
        st_next.nib_hi_done = 1'b0;
        byte_ok = 1'b1;
      end
    end else if (en_fall) begin
      byte_ok = 1'b1;
    end
    case (st_reg.state)
      CLCD_IDLE: begin
        if (byte_ok && !rs_s && !rw_s) begin
          // Instruction write; priority by leading one
          st_next.state = CLCD_BUSY;
          st_next.busy_cnt = 20'(SHORT_CYCLES);
          if (byte_v[7]) begin
            st_next.addr_counter = byte_v[6:0];
            st_next.to_font = 1'b0;
          end else if (byte_v[6]) begin
            st_next.addr_counter = {1'b0, byte_v[5:0]};
            st_next.to_font = 1'b1;
          end else if (byte_v[5]) begin
            st_next.bus_width_8 = byte_v[4];
            st_next.two_line = byte_v[3];
            st_next.font_tall = byte_v[2];
            st_next.nib_hi_done = 1'b0;
          end else if (byte_v[4]) begin
            if (byte_v[3]) begin
              st_next.shift = byte_v[2] ? st_reg.shift + 7'h01 : st_reg.shift - 7'h01;
            end else begin
              st_next.addr_counter = step_addr(st_reg.addr_counter, byte_v[2],
                                               st_reg.to_font, st_reg.two_line);
            end
          end else if (byte_v[3]) begin
            st_next.display_on = byte_v[2];
            st_next.cursor_on = byte_v[1];
            st_next.blink_on = byte_v[0];
          end else if (byte_v[2]) begin
            st_next.incr = byte_v[1];
            st_next.shift_en = byte_v[0];
          end else if (byte_v[1]) begin
            st_next.addr_counter = ADDR_HOME;
            st_next.to_font = 1'b0;
            st_next.shift = 7'h00;
            st_next.busy_cnt = 20'(LONG_CYCLES);
          end else if (byte_v[0]) begin
            st_next.addr_counter = ADDR_HOME;
            st_next.to_font = 1'b0;
            st_next.shift = 7'h00;
            st_next.incr = 1'b1;
            st_next.clr_addr = 7'h00;
            st_next.busy_cnt = 20'(LONG_CYCLES);
            st_next.state = CLCD_CLEAR;
          end
        end else if (byte_ok && rs_s && !rw_s) begin
          // Data write into the RAM chosen by the last address set, clear or home
          ram_we = 1'b1;
          ram_wdata = byte_v;
          na = step_addr(st_reg.addr_counter, st_reg.incr, st_reg.to_font,
                         st_reg.two_line);
          st_next.addr_counter = na;
          if (st_reg.shift_en && !st_reg.to_font) begin
            st_next.shift = st_reg.incr ? st_reg.shift - 7'h01 : st_reg.shift + 7'h01;
          end
          st_next.data_reg = ram_read(na, st_reg.to_font);
          st_next.busy_cnt = 20'(SHORT_CYCLES);
          st_next.state = CLCD_BUSY;
        end else if (en_fall && rs_s && rw_s &&
                     (st_reg.bus_width_8 || st_reg.nib_hi_done)) begin
          // Data read finished; step and prefetch next byte
          na = step_addr(st_reg.addr_counter, st_reg.incr, st_reg.to_font,
                         st_reg.two_line);
          st_next.addr_counter = na;
          st_next.data_reg = ram_read(na, st_reg.to_font);
          st_next.busy_cnt = 20'(SHORT_CYCLES);
          st_next.state = CLCD_BUSY;
        end
      end
      CLCD_CLEAR: begin
        // One space per cycle through the whole display RAM
        ram_we = 1'b1;
        ram_wfont = 1'b0;
        ram_waddr = st_reg.clr_addr;
        ram_wdata = SPACE_CODE;
        st_next.clr_addr = st_reg.clr_addr + 7'h01;
        if (st_reg.clr_addr == 7'h7f) begin
          st_next.state = CLCD_BUSY;
        end
      end
      CLCD_BUSY: begin
        // Bytes arriving now are ignored; four-bit nibble assembly still runs
        if (st_reg.busy_cnt <= 20'h0_0001) begin
          st_next.state = CLCD_IDLE;
          st_next.data_reg = ram_read(st_next.addr_counter, st_reg.to_font);
        end
      end
      default: st_next.state = CLCD_IDLE;
    endcase
    // Read data: status or data register, nibble by nibble in four-bit mode
    if (!rs_s) begin
      st_next.rd_out = {st_reg.state != CLCD_IDLE, st_reg.addr_counter};
    end else begin
      st_next.rd_out = st_reg.data_reg;
    end
    if (!st_reg.bus_width_8 && st_reg.nib_hi_done) begin
      st_next.rd_out = {st_next.rd_out[3:0], 4'h0};
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.incr <= 1'b1;
      st_reg.bus_width_8 <= BUS_WIDTH_RST;
      st_reg.state <= CLCD_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // RAM writes; no reset, contents undefined until written or cleared
  always_ff @(posedge clk) begin
    if (ram_we && ram_wfont) begin
      user_font_ram[ram_waddr[5:0]] <= ram_wdata;
    end else if (ram_we) begin
      display_ram[ram_waddr] <= ram_wdata;
    end
  end

  // Font path for the scan side
  logic [7:0] scan_code;
  logic [5:0] uf_addr;
  assign scan_code = display_ram[scan_addr];

  clcd_font_lookup u_font (
    .char_code(scan_code),
    .row(scan_row),
    .user_font_byte(user_font_ram[uf_addr]),
    .cursor_here(st_reg.cursor_on && scan_addr == st_reg.addr_counter),
    .dots(scan_dots),
    .user_font_addr(uf_addr)
  );

  // Outputs
  assign data_out = st_reg.rd_out;
  assign data_oe = st_reg.sync_en[1] && st_reg.sync_rw[1];
  assign busy_flag = st_reg.state != CLCD_IDLE;
  assign bus_width_8 = st_reg.bus_width_8;
  assign two_line = st_reg.two_line;
  assign font_tall = st_reg.font_tall;
  assign display_on = st_reg.display_on;
  assign cursor_on = st_reg.cursor_on;
  assign blink_on = st_reg.blink_on;
  assign display_shift = st_reg.shift;
  assign com_count = st_reg.two_line ? 5'(COM_TWO_LINE) : 5'(COM_ONE_LINE);
  assign seg_count = 6'(SEG_LINES);

  // Checks
  a_clear_busy: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.state == CLCD_CLEAR |-> busy_flag) else $error("busy low during clear");
  a_busy_holds: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busy_flag) |-> busy_flag [*8]) else $error("busy too short");
  a_home_addr: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.state == CLCD_CLEAR |-> st_reg.addr_counter == ADDR_HOME) else $error("clear addr");
  a_idle_nobusy: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.state == CLCD_IDLE |-> st_reg.busy_cnt <= 20'h0_0001) else $error("idle early");
  a_status_bits: assert property (@(posedge clk) disable iff (!rst_n)
    (!rs_s && st_reg.bus_width_8) |=> data_out[6:0] == $past(st_reg.addr_counter))
    else $error("status read");
  a_font_range: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.to_font |-> !st_reg.addr_counter[6]) else $error("font addr range");
  a_two_line_range: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.state == CLCD_IDLE && ram_we && st_reg.two_line && !st_reg.to_font &&
    st_reg.incr && st_reg.addr_counter == LINE1_LAST) |=> st_reg.addr_counter == LINE2_FIRST)
    else $error("line range");
  a_com_count: assert property (@(posedge clk) disable iff (!rst_n)
    com_count == (two_line ? 5'h10 : 5'h08)) else $error("common count");
  c_clear: cover property (@(posedge clk) st_reg.state == CLCD_CLEAR);
  c_nibble: cover property (@(posedge clk) byte_ok && !st_reg.bus_width_8);
  c_font_wr: cover property (@(posedge clk) ram_we && ram_wfont);
endmodule : clcd_core
`default_nettype wire

/* tb/clcd_host.sv */
// Host processor model on the parallel bus of the display command core.
// Assumes the bench calls its tasks; pins change on falling clock edges.
`timescale 1ns/1ns
`default_nettype none
module clcd_host (
  input wire logic clk,
  input wire logic [7:0] data_out,
  output logic reg_select,
  output logic read_not_write,
  output logic enable,
  output logic [7:0] data_in
);
  // Bus width the host believes in; the bench keeps it in step
  logic wide8 = 1'b1;
  // Idle bus at time zero
  initial begin
    reg_select = 1'b0;
    read_not_write = 1'b1;
    enable = 1'b0;
    data_in = 8'h00;
  end
  // One strobe; enable held long for the pin synchroniser
  task automatic strobe(input logic rs, input logic rw, input logic [7:0] v,
                        output logic [7:0] rd);
    @(negedge clk);
    reg_select = rs;
    read_not_write = rw;
    data_in = rw ? ~data_in : v;
    repeat (2) @(negedge clk);
    enable = 1'b1;
    // Read data taken on a falling edge, away from the edge that launches it
    repeat (6) @(negedge clk);
    rd = data_out;
    @(negedge clk);
    enable = 1'b0;
    repeat (2) @(negedge clk);
    // Released lines must not keep the last value
    data_in = ~data_in;
    repeat (4) @(negedge clk);
  endtask : strobe
  // Whole byte; two nibbles on the top lines in narrow mode
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] v,
                      output logic [7:0] rd);
    logic [7:0] hi;
    logic [7:0] lo;
    if (wide8) begin
      strobe(rs, rw, v, rd);
    end else begin
      strobe(rs, rw, {v[7:4], 4'h0}, hi);
      strobe(rs, rw, {v[3:0], 4'h0}, lo);
      rd = {hi[7:4], lo[7:4]};
    end
  endtask : xfer
  // Status poll until ready; bounded, watchdog covers the rest
  task automatic poll(output logic [7:0] st);
    int n;
    n = 0;
    do begin
      xfer(1'b0, 1'b1, 8'h00, st);
      n++;
    end while (st[7] !== 1'b0 && n < 200);
  endtask : poll
  // Any request only after the core reports ready
  task automatic op(input logic rs, input logic rw, input logic [7:0] v,
                    output logic [7:0] rd);
    logic [7:0] st;
    poll(st);
    xfer(rs, rw, v, rd);
  endtask : op
endmodule : clcd_host
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the display command core with a host model.
// Assumes short busy counts set by parameter; random data from a fixed seed.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import clcd_pkg::*;
;
  localparam int unsigned SH = 40;
  localparam int unsigned LG = 80;
  logic clk = 1'b0;
  logic rst_n;
  logic rs, rnw, en, doe, busy, bw8, two, tall, don, con, bon;
  logic [7:0] din, dout;
  logic [6:0] dshift, saddr;
  logic [4:0] comc, sdots;
  logic [5:0] segc;
  logic [2:0] srow;
  int n_errors = 0;
  int total_checks = 0;
  // Length of the last busy stretch, seen at the pin
  int unsigned run = 0;
  int unsigned last_run = 0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      run <= run + 1;
    end else begin
      if (run != 0) last_run <= run;
      run <= 0;
    end
  end
  // Read turn-around follows the strobe after the two-stage pin delay
  logic [1:0] en_d = 2'h0;
  logic [1:0] rw_d = 2'h0;
  always @(posedge clk) begin
    en_d <= {en_d[0], en};
    rw_d <= {rw_d[0], rnw};
  end
  always @(negedge clk) begin
    if (rst_n === 1'b1) chk({7'h0, doe}, {7'h0, en_d[1] & rw_d[1]});
  end
  clcd_core #(.SHORT_CYCLES(SH), .LONG_CYCLES(LG)) clcd_core_inst (
    .clk(clk), .rst_n(rst_n), .reg_select(rs), .read_not_write(rnw), .enable(en),
    .data_in(din), .data_out(dout), .data_oe(doe), .busy_flag(busy),
    .bus_width_8(bw8), .two_line(two), .font_tall(tall), .display_on(don),
    .cursor_on(con), .blink_on(bon), .display_shift(dshift), .com_count(comc),
    .seg_count(segc), .scan_addr(saddr), .scan_row(srow), .scan_dots(sdots));
  clcd_host clcd_host_inst (.clk(clk), .data_out(dout), .reg_select(rs),
    .read_not_write(rnw), .enable(en), .data_in(din));
  // Value compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Count compare against a window
  task automatic chk_rng(input int unsigned got, input int unsigned lo, input int unsigned hi);
    total_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, lo);
    end
  endtask : chk_rng
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  // Short forms: instruction, data write, data read, ready status
  task automatic c(input logic [7:0] v);
    logic [7:0] d;
    clcd_host_inst.op(1'b0, 1'b0, v, d);
  endtask : c
  task automatic w(input logic [7:0] v);
    logic [7:0] d;
    clcd_host_inst.op(1'b1, 1'b0, v, d);
  endtask : w
  task automatic r(output logic [7:0] v);
    clcd_host_inst.op(1'b1, 1'b1, 8'h00, v);
  endtask : r
  task automatic st(output logic [7:0] v);
    clcd_host_inst.poll(v);
  endtask : st
  // Watchdog well beyond the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [7:0] d, s, x;
    logic [7:0] m [8];
    logic [6:0] a;
    int unused;
    rst_n = 1'b0;
    saddr = 7'h00;
    srow = 3'h0;
    unused = $urandom(32'h57745c50);
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    chk({7'h0, bw8}, 8'h01);
    st(s);
    chk(s, 8'h00);
    c(8'h01);
    st(s);
    chk(s, 8'h00);
    chk_rng(last_run, LG, LG + 130);
    // Every line and font setting in wide mode
    for (int j = 0; j < 4; j++) begin
      c(8'h30 | 8'(j << 2));
      chk({6'h0, two, tall}, 8'(j));
      chk({3'h0, comc}, j[1] ? 8'(COM_TWO_LINE) : 8'(COM_ONE_LINE));
      chk({2'h0, segc}, 8'(SEG_LINES));
    end
    c(8'h38);
    st(s);
    chk_rng(last_run, SH, SH + 2);
    for (int i = 0; i < 8; i++) begin
      c({5'b00001, i[2:0]});
      chk({5'h0, don, con, bon}, 8'(i));
    end
    // Random bytes written up, read back, then one written downward
    a = 7'($urandom_range(31));
    c(8'h06);
    c({1'b1, a});
    for (int i = 0; i < 8; i++) begin
      m[i] = 8'($urandom);
      w(m[i]);
    end
    st(s);
    chk(s, {1'b0, a + 7'h08});
    c({1'b1, a});
    for (int i = 0; i < 8; i++) begin
      r(d);
      chk(d, m[i]);
    end
    c(8'h04);
    c({1'b1, a + 7'h07});
    w(8'h5a);
    st(s);
    chk(s, {1'b0, a + 7'h06});
    // Clear leaves spaces in the eight cells written before
    c(8'h01);
    st(s);
    chk(s, 8'h00);
    c({1'b1, a});
    for (int i = 0; i < 8; i++) begin
      r(d);
      chk(d, SPACE_CODE);
    end
    // Cursor moves, line wrap, display shift and home
    c(8'ha7);
    w(8'h41);
    st(s);
    chk(s, 8'h40);
    c(8'ha7);
    c(8'h14);
    st(s);
    chk(s, 8'h40);
    c(8'h14);
    c(8'h10);
    st(s);
    chk(s, 8'h40);
    c(8'h18);
    st(s);
    chk(s, 8'h40);
    chk({7'h0, |dshift}, 8'h01);
    c(8'h02);
    st(s);
    chk(s, 8'h00);
    chk({1'b0, dshift}, 8'h00);
    // User fonts shown through the scan port, cursor off
    c(8'h0c);
    for (int k = 0; k < 2; k++) begin
      x = {4'h0, k[0], 3'($urandom)};
      c(8'h40 | {2'h0, x[2:0], 3'h0});
      for (int i = 0; i < 8; i++) begin
        m[i] = 8'($urandom);
        w(m[i]);
      end
      c(8'h80);
      w(x);
      for (int i = 0; i < 8; i++) begin
        @(negedge clk);
        saddr = 7'h00;
        srow = 3'(i);
        repeat (3) @(negedge clk);
        chk({3'h0, sdots}, {3'h0, m[i][4:0]});
      end
    end
    // Cursor on the scanned cell lights the whole eighth row
    c(8'h0e);
    c(8'h80);
    @(negedge clk);
    srow = 3'h7;
    repeat (3) @(negedge clk);
    chk({3'h0, sdots}, 8'h1f);
    // Instruction sent while busy must be dropped
    c(8'h08);
    clcd_host_inst.xfer(1'b0, 1'b0, 8'h0f, d);
    st(s);
    chk({7'h0, don}, 8'h00);
    // Narrow bus: nibble pairs both ways
    c(8'h28);
    clcd_host_inst.wide8 = 1'b0;
    st(s);
    chk({7'h0, bw8}, 8'h00);
    x = 8'($urandom);
    c({1'b1, a});
    w(x);
    c({1'b1, a});
    r(d);
    chk(d, x);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
